/* File: gp_pkg.sv */
// Functional notes
// - direction one tristates pin as input
// - direction zero drives latch onto pin
// - data read returns pins, write sets latch
// - writes are read-modify-write on pin levels; the code stores the written byte whole in the latch
// - direction governs driver even when analog
// - analog pins read as zero
// - analog select forces digital reads zero
// - analog select leaves digital output unaffected
// - data registers eight bits, undefined after reset
// - direction registers reset to all ones
// - fourth port eight bits bidirectional
// - absent fourth port reads zero
// - select bit places second capcomp pin
// - bit0 timer osc/clock, bit1 osc in/capcomp
// - bit2 first capcomp unit
// - bits3-5 serial clock, data in, out
// - bits6-7 async serial or sync serial
// - analog select resets to all ones
package gp_pkg;
    localparam logic [3:0] ADDR_THIRD_DATA = 4'h0;
    localparam logic [3:0] ADDR_THIRD_DIR = 4'h1;
    localparam logic [3:0] ADDR_ALT_SEL = 4'h2;
    localparam logic [3:0] ADDR_FOURTH_DATA = 4'h3;
    localparam logic [3:0] ADDR_FOURTH_DIR = 4'h4;
    localparam logic [3:0] ADDR_FOURTH_ANA = 4'h5;
    localparam logic [7:0] DIR_RESET = 8'hff;
    localparam logic [7:0] ANA_RESET = 8'hff;
    localparam logic [7:0] ALT_RESET = 8'h00;
    localparam logic [7:0] ALT_MASK = 8'h03;
    localparam int CAPCOMP2_SEL_BIT = 0;
    // peripheral request to take over pins, one bit per pin of the port
    typedef struct packed {
        logic [7:0] claim;
        logic [7:0] drive;
        logic [7:0] out_en;
    } gp_periph_t;
    typedef struct packed {
        logic [7:0] third_latch;
        logic [7:0] third_dir;
        logic [7:0] alt_sel;
        logic [7:0] fourth_latch;
        logic [7:0] fourth_dir;
        logic [7:0] fourth_ana;
        logic [31:0] rdata;
        logic rvalid;
    } gp_state_t;
endpackage

/* File: gp_ports.sv */
// The Avalon-MM interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
module gp_ports #(
    parameter bit HAS_FOURTH = 1'b1
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [5:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic [7:0] i_third_pin,
    output logic [7:0] o_third_pin,
    output logic [7:0] o_third_pin_oe_n,
    input wire logic [7:0] i_fourth_pin,
    output logic [7:0] o_fourth_pin,
    output logic [7:0] o_fourth_pin_oe_n,
    input wire gp_pkg::gp_periph_t i_third_periph,
    input wire logic i_capcomp2_drive,
    input wire logic i_capcomp2_out_en,
    input wire logic i_capcomp2_enable,
    output logic o_capcomp2_on_third,
    output logic [7:0] o_third_periph_in
);
    gp_pkg::gp_state_t st_reg;
    gp_pkg::gp_state_t st_next;
    gp_pkg::gp_periph_t merged;
    logic [3:0] idx;
    logic wr_ok;
    logic [7:0] wbyte;
    logic [7:0] third_rd;
    logic [7:0] fourth_rd;

    // fourth port registers read as zero when the port is not built
    function automatic logic [7:0] fourth_view(input logic [7:0] v);
        if (HAS_FOURTH) begin
            return v;
        end
        return 8'h00;
    endfunction

    // word index; only lane 0 carries data
    assign idx = i_avs_address[5:2];
    assign wr_ok = i_avs_write && i_avs_byteenable[0];
    assign wbyte = i_avs_writedata[7:0];

    // second capcomp unit lands on bit1 of this port when select bit set
    always_comb begin
        merged = i_third_periph;
        o_capcomp2_on_third = st_reg.alt_sel[gp_pkg::CAPCOMP2_SEL_BIT];
        if (o_capcomp2_on_third && i_capcomp2_enable) begin
            merged.claim[1] = 1'b1;
            merged.drive[1] = i_capcomp2_drive;
            merged.out_en[1] = i_capcomp2_out_en;
        end
    end

    // pin drivers: peripheral claim overrides latch and direction
    always_comb begin
        for (int b = 0; b < 8; b++) begin
            if (merged.claim[b]) begin
                o_third_pin[b] = merged.drive[b];
                o_third_pin_oe_n[b] = ~merged.out_en[b];
            end else begin
                o_third_pin[b] = st_reg.third_latch[b];
                o_third_pin_oe_n[b] = st_reg.third_dir[b];
            end
        end
        // analog select does not touch output path
        o_fourth_pin = HAS_FOURTH ? st_reg.fourth_latch : 8'h00;
        o_fourth_pin_oe_n = HAS_FOURTH ? st_reg.fourth_dir : 8'hff;
    end

    // pin levels seen by software
    assign third_rd = i_third_pin;
    assign fourth_rd = fourth_view(i_fourth_pin & ~st_reg.fourth_ana);
    assign o_third_periph_in = i_third_pin;

    // register next state; reads answered one cycle later
    always_comb begin
        st_next = st_reg;
        st_next.rvalid = 1'b0;
        st_next.rdata = 32'h0000_0000;
        if (i_avs_read && !st_reg.rvalid) begin
            st_next.rvalid = 1'b1;
            unique case (idx)
                gp_pkg::ADDR_THIRD_DATA: st_next.rdata[7:0] = third_rd;
                gp_pkg::ADDR_THIRD_DIR: st_next.rdata[7:0] = st_reg.third_dir;
                gp_pkg::ADDR_ALT_SEL: st_next.rdata[7:0] = st_reg.alt_sel;
                gp_pkg::ADDR_FOURTH_DATA: st_next.rdata[7:0] = fourth_rd;
                gp_pkg::ADDR_FOURTH_DIR:
                    st_next.rdata[7:0] = fourth_view(st_reg.fourth_dir);
                gp_pkg::ADDR_FOURTH_ANA:
                    st_next.rdata[7:0] = fourth_view(st_reg.fourth_ana);
                default: st_next.rdata = 32'h0000_0000;
            endcase
        end
        if (wr_ok) begin
            unique case (idx)
                // whole byte replaces the latch; pin image read is discarded
                gp_pkg::ADDR_THIRD_DATA: st_next.third_latch = wbyte;
                gp_pkg::ADDR_THIRD_DIR: st_next.third_dir = wbyte;
                gp_pkg::ADDR_ALT_SEL: st_next.alt_sel = wbyte & gp_pkg::ALT_MASK;
                gp_pkg::ADDR_FOURTH_DATA: st_next.fourth_latch = wbyte;
                gp_pkg::ADDR_FOURTH_DIR: st_next.fourth_dir = wbyte;
                gp_pkg::ADDR_FOURTH_ANA: st_next.fourth_ana = wbyte;
                default: st_next.rvalid = st_next.rvalid;
            endcase
        end
    end

    // data latches keep contents over reset (undefined value)
    always_ff @(posedge i_clk) begin
        st_reg <= st_next;
        if (i_sys_rst) begin
            st_reg.third_dir <= gp_pkg::DIR_RESET;
            st_reg.fourth_dir <= gp_pkg::DIR_RESET;
            st_reg.fourth_ana <= gp_pkg::ANA_RESET;
            st_reg.alt_sel <= gp_pkg::ALT_RESET;
            st_reg.rvalid <= 1'b0;
            st_reg.rdata <= 32'h0000_0000;
        end
    end

    // writes finish at once, reads wait one cycle
    assign o_avs_waitrequest = i_avs_read && !st_reg.rvalid;
    assign o_avs_readdata = st_reg.rdata;

    // directions come out of reset as all inputs
    property p_dir_reset;
        @(posedge i_clk)
        i_sys_rst |=> (st_reg.third_dir == 8'hff && st_reg.fourth_dir == 8'hff);
    endproperty
    a_dir_reset: assert property (p_dir_reset)
        else $error("direction not all ones after reset");

    // analog select comes out of reset as all analog, alt select clear
    property p_ana_reset;
        @(posedge i_clk)
        i_sys_rst |=> (st_reg.fourth_ana == 8'hff && st_reg.alt_sel == 8'h00);
    endproperty
    a_ana_reset: assert property (p_ana_reset)
        else $error("analog or alt select wrong after reset");

    // input pin is released
    property p_input_tristate;
        @(posedge i_clk) disable iff (i_sys_rst)
        (!merged.claim[0] && st_reg.third_dir[0]) |-> o_third_pin_oe_n[0];
    endproperty
    a_input_tristate: assert property (p_input_tristate)
        else $error("input pin driven");

    // fourth port all inputs means no pin driven
    property p_fourth_tristate;
        @(posedge i_clk) disable iff (i_sys_rst)
        (st_reg.fourth_dir == 8'hff) |-> (o_fourth_pin_oe_n == 8'hff);
    endproperty
    a_fourth_tristate: assert property (p_fourth_tristate)
        else $error("fourth port input pin driven");

    // output pin drives its latch
    property p_drive_latch;
        @(posedge i_clk) disable iff (i_sys_rst)
        (!merged.claim[3] && !st_reg.third_dir[3]) |->
        (!o_third_pin_oe_n[3] && o_third_pin[3] == st_reg.third_latch[3]);
    endproperty
    a_drive_latch: assert property (p_drive_latch)
        else $error("output pin not driving latch");

    // fourth port outputs drive their latch
    property p_drive_fourth;
        @(posedge i_clk) disable iff (i_sys_rst)
        (HAS_FOURTH && st_reg.fourth_dir == 8'h00) |-> (o_fourth_pin == st_reg.fourth_latch);
    endproperty
    a_drive_fourth: assert property (p_drive_fourth)
        else $error("fourth port not driving latch");

    // analog pins read back as zero
    property p_analog_zero;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_avs_read && !st_reg.rvalid && idx == gp_pkg::ADDR_FOURTH_DATA) |=>
        ((st_reg.rdata[7:0] & $past(st_reg.fourth_ana)) == 8'h00);
    endproperty
    a_analog_zero: assert property (p_analog_zero)
        else $error("analog pin read nonzero");

    // analog select leaves output drivers alone
    property p_analog_drive;
        @(posedge i_clk) disable iff (i_sys_rst)
        (HAS_FOURTH && st_reg.fourth_ana == 8'hff && st_reg.fourth_dir == 8'h00) |->
        (o_fourth_pin_oe_n == 8'h00);
    endproperty
    a_analog_drive: assert property (p_analog_drive)
        else $error("analog select blocked output");

    // write stores the byte in the third port latch
    property p_write_latch;
        @(posedge i_clk) disable iff (i_sys_rst)
        (wr_ok && idx == gp_pkg::ADDR_THIRD_DATA) |=> st_reg.third_latch == $past(wbyte);
    endproperty
    a_write_latch: assert property (p_write_latch)
        else $error("latch not updated by write");

    // write stores the byte in the fourth port latch
    property p_write_fourth;
        @(posedge i_clk) disable iff (i_sys_rst)
        (wr_ok && idx == gp_pkg::ADDR_FOURTH_DATA) |=> st_reg.fourth_latch == $past(wbyte);
    endproperty
    a_write_fourth: assert property (p_write_fourth)
        else $error("fourth latch not updated by write");

    // write stores the third port direction
    property p_write_dir;
        @(posedge i_clk) disable iff (i_sys_rst)
        (wr_ok && idx == gp_pkg::ADDR_THIRD_DIR) |=> st_reg.third_dir == $past(wbyte);
    endproperty
    a_write_dir: assert property (p_write_dir)
        else $error("direction not updated by write");

    // direction holds when not written
    property p_dir_hold;
        @(posedge i_clk) disable iff (i_sys_rst)
        !(wr_ok && idx == gp_pkg::ADDR_THIRD_DIR) |=> st_reg.third_dir == $past(st_reg.third_dir);
    endproperty
    a_dir_hold: assert property (p_dir_hold)
        else $error("direction changed without write");

    // alt select keeps only its implemented bits
    property p_write_alt;
        @(posedge i_clk) disable iff (i_sys_rst)
        (wr_ok && idx == gp_pkg::ADDR_ALT_SEL) |=> st_reg.alt_sel == ($past(wbyte) & 8'h03);
    endproperty
    a_write_alt: assert property (p_write_alt)
        else $error("alt select write wrong");

    // unimplemented alt select bits stay clear
    property p_alt_mask;
        @(posedge i_clk) disable iff (i_sys_rst)
        st_reg.alt_sel[7:2] == 6'h00;
    endproperty
    a_alt_mask: assert property (p_alt_mask)
        else $error("alt select upper bits set");

    // data read returns pin levels after one wait cycle
    property p_pin_read;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_avs_read && !st_reg.rvalid && idx == gp_pkg::ADDR_THIRD_DATA) |=>
        (o_avs_readdata[7:0] == $past(i_third_pin) && !o_avs_waitrequest);
    endproperty
    a_pin_read: assert property (p_pin_read)
        else $error("pin read wrong");

    // a fresh read is stalled
    property p_read_wait;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_avs_read && !st_reg.rvalid) |-> o_avs_waitrequest;
    endproperty
    a_read_wait: assert property (p_read_wait)
        else $error("read not stalled");

    // read answer follows one cycle later
    property p_read_answer;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_avs_read && !st_reg.rvalid) |=> st_reg.rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read not answered");

    // writes without a read are never stalled
    property p_write_no_wait;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_avs_write && !i_avs_read) |-> !o_avs_waitrequest;
    endproperty
    a_write_no_wait: assert property (p_write_no_wait)
        else $error("write stalled");

    // only the low byte ever carries data
    property p_rdata_upper;
        @(posedge i_clk) disable iff (i_sys_rst)
        o_avs_readdata[31:8] == 24'h00_0000;
    endproperty
    a_rdata_upper: assert property (p_rdata_upper)
        else $error("read data upper bits set");

    // read data is zero outside an answer
    property p_rdata_idle;
        @(posedge i_clk) disable iff (i_sys_rst)
        !st_reg.rvalid |-> o_avs_readdata == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not idle");

    // analog select reads back as stored
    property p_ana_read;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_avs_read && !st_reg.rvalid && idx == gp_pkg::ADDR_FOURTH_ANA) |=>
        (o_avs_readdata[7:0] == (HAS_FOURTH ? $past(st_reg.fourth_ana) : 8'h00));
    endproperty
    a_ana_read: assert property (p_ana_read)
        else $error("analog select read wrong");

    // absent fourth port reads zero
    property p_absent_read;
        @(posedge i_clk) disable iff (i_sys_rst)
        (!HAS_FOURTH && i_avs_read && !st_reg.rvalid && idx == gp_pkg::ADDR_FOURTH_DATA) |=>
        (o_avs_readdata == 32'h0000_0000);
    endproperty
    a_absent_read: assert property (p_absent_read)
        else $error("absent port read nonzero");

    // absent fourth port never drives its pins
    property p_absent_pins;
        @(posedge i_clk) disable iff (i_sys_rst)
        !HAS_FOURTH |-> (o_fourth_pin_oe_n == 8'hff);
    endproperty
    a_absent_pins: assert property (p_absent_pins)
        else $error("absent port drives pins");

    // claimed pin carries the peripheral value
    property p_claim;
        @(posedge i_clk) disable iff (i_sys_rst)
        merged.claim[6] |-> o_third_pin[6] == merged.drive[6];
    endproperty
    a_claim: assert property (p_claim)
        else $error("peripheral not routed");

    // claimed pin direction follows the peripheral
    property p_claim_oe;
        @(posedge i_clk) disable iff (i_sys_rst)
        merged.claim[6] |-> o_third_pin_oe_n[6] == !merged.out_en[6];
    endproperty
    a_claim_oe: assert property (p_claim_oe)
        else $error("peripheral direction not routed");

    // timer oscillator pin direction follows the peripheral
    property p_bit0_timer;
        @(posedge i_clk) disable iff (i_sys_rst)
        i_third_periph.claim[0] |-> o_third_pin_oe_n[0] == !i_third_periph.out_en[0];
    endproperty
    a_bit0_timer: assert property (p_bit0_timer)
        else $error("timer pin direction wrong");

    // first capcomp unit drives bit2
    property p_bit2_capcomp;
        @(posedge i_clk) disable iff (i_sys_rst)
        i_third_periph.claim[2] |-> o_third_pin[2] == i_third_periph.drive[2];
    endproperty
    a_bit2_capcomp: assert property (p_bit2_capcomp)
        else $error("first capcomp not routed");

    // serial data out drives bit5
    property p_bit5_serial;
        @(posedge i_clk) disable iff (i_sys_rst)
        i_third_periph.claim[5] |-> o_third_pin[5] == i_third_periph.drive[5];
    endproperty
    a_bit5_serial: assert property (p_bit5_serial)
        else $error("serial output not routed");

    // peripherals see the pin levels
    property p_periph_in;
        @(posedge i_clk) disable iff (i_sys_rst)
        o_third_periph_in == i_third_pin;
    endproperty
    a_periph_in: assert property (p_periph_in)
        else $error("peripheral input wrong");

    // second capcomp unit placed on bit1 when selected
    property p_route2;
        @(posedge i_clk) disable iff (i_sys_rst)
        (st_reg.alt_sel[0] && i_capcomp2_enable) |-> o_third_pin[1] == i_capcomp2_drive;
    endproperty
    a_route2: assert property (p_route2)
        else $error("second capcomp not placed");

    // bit1 stays with the port when not selected
    property p_route2_off;
        @(posedge i_clk) disable iff (i_sys_rst)
        (!st_reg.alt_sel[0] && !i_third_periph.claim[1]) |->
        (o_third_pin_oe_n[1] == st_reg.third_dir[1]);
    endproperty
    a_route2_off: assert property (p_route2_off)
        else $error("second capcomp placed while off");
endmodule

/* File: gp_pad_model.sv */
`timescale 1ns/1ps
// pad model: a driven pad shows the driver, a released pad the outside level
module gp_pad_model (
    input wire logic [7:0] i_drive,
    input wire logic [7:0] i_oe_n,
    input wire logic [7:0] i_outside,
    output logic [7:0] o_level
);
    // resolve each pad bit
    assign o_level = (i_drive & ~i_oe_n) | (i_outside & i_oe_n);
endmodule

/* File: tb_gp_ports.sv */
`timescale 1ns/1ps
module tb_gp_ports;
    logic clk = 0, rst = 1, rd_en = 0, wr_en = 0, wait_req, cc_en = 0;
    logic [5:0] addr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [7:0] ext3 = 8'h96, ext4 = 8'hff, tp, tpo, toe, fp, fpo, foe, q;
    logic [31:0] rdata2;
    logic [7:0] q2, pin_in;
    logic on3;
    gp_pkg::gp_periph_t periph = '0;
    int bad_count = 0, comparisons = 0;
    always #2.5 clk = ~clk;
    gp_pad_model i_pad3 (.i_drive(tpo), .i_oe_n(toe), .i_outside(ext3), .o_level(tp));
    gp_pad_model i_pad4 (.i_drive(fpo), .i_oe_n(foe), .i_outside(ext4), .o_level(fp));
    gp_ports i_dut (.i_clk(clk), .i_sys_rst(rst), .i_avs_address(addr), .i_avs_read(rd_en),
        .i_avs_write(wr_en), .i_avs_writedata(wdata), .i_avs_byteenable(4'h1),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req), .i_third_pin(tp),
        .o_third_pin(tpo), .o_third_pin_oe_n(toe), .i_fourth_pin(fp), .o_fourth_pin(fpo),
        .o_fourth_pin_oe_n(foe), .i_third_periph(periph), .i_capcomp2_drive(cc_en),
        .i_capcomp2_out_en(cc_en), .i_capcomp2_enable(cc_en), .o_capcomp2_on_third(on3),
        .o_third_periph_in(pin_in));
    // variant without the fourth port, sharing the bus
    gp_ports #(.HAS_FOURTH(1'b0)) i_dut_nof (.i_clk(clk), .i_sys_rst(rst), .i_avs_address(addr),
        .i_avs_read(rd_en), .i_avs_write(wr_en), .i_avs_writedata(wdata),
        .i_avs_byteenable(4'h1), .o_avs_readdata(rdata2), .o_avs_waitrequest(),
        .i_third_pin(tp), .o_third_pin(), .o_third_pin_oe_n(), .i_fourth_pin(fp),
        .o_fourth_pin(), .o_fourth_pin_oe_n(), .i_third_periph(periph),
        .i_capcomp2_drive(cc_en), .i_capcomp2_out_en(cc_en), .i_capcomp2_enable(cc_en),
        .o_capcomp2_on_third(), .o_third_periph_in());
    task report_and_stop;
        $display("checks %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // one bus cycle held until waitrequest is seen low
    task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        int n;
        addr <= {a, 2'b00};
        wdata <= {24'h0, d};
        wr_en <= w;
        rd_en <= ~w;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (wait_req === 1'b0) break;
        end
        if (n >= 50) begin
            bad_count++;
            report_and_stop();
        end
        q = rdata[7:0];
        q2 = rdata2[7:0];
        wr_en <= 0;
        rd_en <= 0;
        @(posedge clk);
    endtask
    task rd(input logic [3:0] a, input logic [7:0] e);
        bus(0, a, 8'h00);
        chk(q, e);
    endtask
    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst <= 0;
        rd(gp_pkg::ADDR_THIRD_DIR, 8'hff);
        rd(gp_pkg::ADDR_FOURTH_DIR, 8'hff);
        rd(gp_pkg::ADDR_FOURTH_ANA, 8'hff);
        rd(gp_pkg::ADDR_ALT_SEL, 8'h00);
        rd(4'hf, 8'h00);
        chk(toe, 8'hff);
        rd(gp_pkg::ADDR_THIRD_DATA, 8'h96);
        chk(pin_in, 8'h96);
        rd(gp_pkg::ADDR_FOURTH_DATA, 8'h00);
        bus(1, gp_pkg::ADDR_FOURTH_ANA, 8'h00);
        ext4 <= 8'ha5;
        rd(gp_pkg::ADDR_FOURTH_DATA, 8'ha5);
        chk(q2, 8'h00);
        bus(1, gp_pkg::ADDR_THIRD_DATA, 8'h3c);
        bus(1, gp_pkg::ADDR_THIRD_DIR, 8'h0f);
        chk(toe, 8'h0f);
        rd(gp_pkg::ADDR_THIRD_DATA, 8'h36);
        bus(1, gp_pkg::ADDR_FOURTH_ANA, 8'hff);
        bus(1, gp_pkg::ADDR_FOURTH_DATA, 8'h5a);
        bus(1, gp_pkg::ADDR_FOURTH_DIR, 8'h00);
        chk(fpo, 8'h5a);
        chk(foe, 8'h00);
        rd(gp_pkg::ADDR_FOURTH_DATA, 8'h00);
        bus(1, gp_pkg::ADDR_ALT_SEL, 8'hff);
        rd(gp_pkg::ADDR_ALT_SEL, 8'h03);
        chk(on3, 1'b1);
        cc_en <= 1;
        periph <= '{claim: 8'h41, drive: 8'h40, out_en: 8'h41};
        @(negedge clk);
        chk({toe[1], tpo[1]}, 2'b01);
        chk({toe[0], tpo[6]}, 2'b01);
        report_and_stop();
    end
endmodule
